// *** phx_defines.svh ***
`ifndef PHX_DEFINES_SVH
`define PHX_DEFINES_SVH

// Notes on behaviour
// - Capability register reads fixed 0x3000 pattern
// - Fast descrambler lock and link shown live
// - Fast error flags self-clear; low byte zero
// - Gigabit descrambler lock and link shown live
// - Gigabit error flags self-clear on read
// - Legacy partner detection flag in bit six
// - Crossover error flag; low five bits zero
// - Bit fifteen disables the transmitter
// - Bits fourteen to twelve bypass coding stages
// - Bits eleven and ten bypass PCS paths
// - Bit nine bypasses inhibit timer; bit eight reserved
// - Sticky bit seven disables forced-speed crossover
// - Sticky bit six turns legacy detection off
// - Sticky bits disable pair swap, polarity fix
// - Sticky bit three honours advertised ability
// - Bit two disables pulse shaping filter
// - Sticky bit one stops automatic next pages
// - Clock output enable defaults from strap
// - Sticky bits survive soft reset when enabled

// ==========================================================
// Register addresses
`define PHX_ADDR_CAP            5'h0F
`define PHX_ADDR_FAST           5'h10
`define PHX_ADDR_GIGA           5'h11
`define PHX_ADDR_BYPASS         5'h12

// ==========================================================
// Fixed and default values
`define PHX_CAP_VALUE           16'h3000
`define PHX_BYPASS_DEFAULT      16'h0088
`define PHX_BYPASS_WR_MASK      16'hFEFF
`define PHX_BYPASS_STICKY_MASK  16'h00FB
`define PHX_UNMAPPED_VALUE      16'h0000

// ==========================================================
// Path bypass control field positions
`define PHX_BYP_TX_DISABLE      15
`define PHX_BYP_4B5B            14
`define PHX_BYP_SCRAMBLER       13
`define PHX_BYP_DESCRAMBLER     12
`define PHX_BYP_PCS_RX          11
`define PHX_BYP_PCS_TX          10
`define PHX_BYP_FAIL_INHIBIT    9
`define PHX_BYP_RESERVED        8
`define PHX_BYP_MDIX_FORCED     7
`define PHX_BYP_LEGACY_DIS      6
`define PHX_BYP_PAIR_SWAP_DIS   5
`define PHX_BYP_POLARITY_DIS    4
`define PHX_BYP_PARALLEL_DET    3
`define PHX_BYP_PULSE_SHAPE     2
`define PHX_BYP_NEXT_PAGE_DIS   1
`define PHX_BYP_CLK_OUT_EN      0

// ==========================================================
// Event vector widths
`define PHX_FAST_EVENTS         6
`define PHX_GIGA_EVENTS         7

`endif

// *** phx_mgmt_host.sv ***
// ==========================================================
// Management controller driving the register port
module phx_mgmt_host (
    input  wire logic               clk_sys,
    output phx_pkg::phx_addr_t      mgmt_addr,
    output logic                    mgmt_rd,
    output logic                    mgmt_wr,
    output phx_pkg::phx_word_t      mgmt_wdata,
    input  wire phx_pkg::phx_word_t mgmt_rdata,
    input  wire logic               mgmt_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        mgmt_addr  = 5'h1F;
        mgmt_rd    = 1'b0;
        mgmt_wr    = 1'b0;
        mgmt_wdata = 16'h0000;
    end

    // Request from one falling edge to the next; released bus shows inverse
    task automatic rd(input phx_pkg::phx_addr_t addr, output phx_pkg::phx_word_t data, output logic ok);
        @(negedge clk_sys);
        mgmt_addr = addr;
        mgmt_rd   = 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        ok        = mgmt_rvalid;
        data      = mgmt_rdata;
        mgmt_rd   = 1'b0;
        mgmt_addr = ~addr;
    endtask : rd

    // Software forces the resolved configuration through this write
    task automatic wr(input phx_pkg::phx_addr_t addr, input phx_pkg::phx_word_t data);
        @(negedge clk_sys);
        mgmt_addr  = addr;
        mgmt_wdata = data;
        mgmt_wr    = 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        mgmt_wr    = 1'b0;
        mgmt_addr  = ~addr;
        mgmt_wdata = ~data;
    endtask : wr

endmodule : phx_mgmt_host

// *** phx_pkg.sv ***
package phx_pkg;

    typedef logic [15:0] phx_word_t;
    typedef logic [4:0]  phx_addr_t;

endpackage : phx_pkg

// *** phx_regs.sv ***
`include "phx_defines.svh"

module phx_regs (
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic                         soft_reset,
    input  wire logic                         sticky_reset_enable,
    input  wire logic                         config_strap_default,
    input  wire phx_pkg::phx_addr_t           mgmt_addr,
    input  wire logic                         mgmt_rd,
    input  wire logic                         mgmt_wr,
    input  wire phx_pkg::phx_word_t           mgmt_wdata,
    output phx_pkg::phx_word_t                mgmt_rdata,
    output logic                              mgmt_rvalid,
    input  wire logic                         fast_descrambler_locked,
    input  wire logic                         fast_link_up,
    input  wire logic [`PHX_FAST_EVENTS-1:0]  fast_event,
    input  wire logic                         giga_descrambler_locked,
    input  wire logic                         giga_link_up,
    input  wire logic [`PHX_GIGA_EVENTS-1:0]  giga_event,
    input  wire logic                         legacy_partner_seen,
    input  wire logic                         crossover_error_seen,
    output logic                              tx_disable,
    output logic                              bypass_4b5b,
    output logic                              bypass_scrambler,
    output logic                              bypass_descrambler,
    output logic                              bypass_pcs_rx,
    output logic                              bypass_pcs_tx,
    output logic                              bypass_link_fail_inhibit_timer,
    output logic                              forced_auto_mdix_disable,
    output logic                              legacy_detect_disable,
    output logic                              pair_swap_disable,
    output logic                              polarity_correct_disable,
    output logic                              parallel_detect_honour,
    output logic                              pulse_shaping_disable,
    output logic                              auto_next_page_disable,
    output logic                              clock_output_pin_enable
);

    // =======================================================
    // Helpers
    function automatic logic phx_hit(input phx_pkg::phx_addr_t a, input phx_pkg::phx_addr_t target);
        phx_hit = (a == target);
    endfunction : phx_hit

    function automatic phx_pkg::phx_word_t phx_bypass_default(input logic strap);
        phx_bypass_default = `PHX_BYPASS_DEFAULT | {15'h0000, strap};
    endfunction : phx_bypass_default

    // =======================================================
    // Declarations
    phx_pkg::phx_word_t                ctrl;
    phx_pkg::phx_word_t                next_rdata;
    logic                              strap_done;
    logic                              strap_latched;
    logic [`PHX_FAST_EVENTS-1:0]       fast_flags;
    logic [`PHX_GIGA_EVENTS-1:0]       giga_flags;
    logic                              legacy_live;
    logic                              rd_cap;
    logic                              rd_fast;
    logic                              rd_giga;
    logic                              rd_bypass;
    logic                              wr_bypass;
    logic                              fast_clear;
    logic                              giga_clear;

    assign rd_cap     = mgmt_rd && phx_hit(mgmt_addr, `PHX_ADDR_CAP);
    assign rd_fast    = mgmt_rd && phx_hit(mgmt_addr, `PHX_ADDR_FAST);
    assign rd_giga    = mgmt_rd && phx_hit(mgmt_addr, `PHX_ADDR_GIGA);
    assign rd_bypass  = mgmt_rd && phx_hit(mgmt_addr, `PHX_ADDR_BYPASS);
    assign wr_bypass  = mgmt_wr && phx_hit(mgmt_addr, `PHX_ADDR_BYPASS);
    assign fast_clear = rd_fast || soft_reset;
    assign giga_clear = rd_giga || soft_reset;

    // Detection is suppressed while its disable is set
    assign legacy_live = legacy_partner_seen && !ctrl[`PHX_BYP_LEGACY_DIS];

    // =======================================================
    // Self-clearing event flags
    phx_sticky_flag #(
        .W (`PHX_FAST_EVENTS)
    ) u_fast_flags (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .event_in (fast_event),
        .clear    (fast_clear),
        .flags    (fast_flags)
    );

    phx_sticky_flag #(
        .W (`PHX_GIGA_EVENTS)
    ) u_giga_flags (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .event_in (giga_event),
        .clear    (giga_clear),
        .flags    (giga_flags)
    );

    // =======================================================
    // Strap capture after reset release
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strap_done <= 1'b0;
        end else begin
            strap_done <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strap_latched <= 1'b0;
        end else if (!strap_done) begin
            strap_latched <= config_strap_default;
        end
    end

    // =======================================================
    // Path bypass control register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl <= `PHX_BYPASS_DEFAULT;
        end else if (!strap_done) begin
            ctrl <= phx_bypass_default(config_strap_default);
        end else if (soft_reset) begin
            if (sticky_reset_enable) begin
                ctrl <= (ctrl & `PHX_BYPASS_STICKY_MASK) | (`PHX_BYPASS_DEFAULT & ~`PHX_BYPASS_STICKY_MASK);
            end else begin
                ctrl <= phx_bypass_default(strap_latched);
            end
        end else if (wr_bypass) begin
            ctrl <= mgmt_wdata & `PHX_BYPASS_WR_MASK;
        end
    end

    assign tx_disable                     = ctrl[`PHX_BYP_TX_DISABLE];
    assign bypass_4b5b                    = ctrl[`PHX_BYP_4B5B];
    assign bypass_scrambler               = ctrl[`PHX_BYP_SCRAMBLER];
    assign bypass_descrambler             = ctrl[`PHX_BYP_DESCRAMBLER];
    assign bypass_pcs_rx                  = ctrl[`PHX_BYP_PCS_RX];
    assign bypass_pcs_tx                  = ctrl[`PHX_BYP_PCS_TX];
    assign bypass_link_fail_inhibit_timer = ctrl[`PHX_BYP_FAIL_INHIBIT];
    assign forced_auto_mdix_disable       = ctrl[`PHX_BYP_MDIX_FORCED];
    assign legacy_detect_disable          = ctrl[`PHX_BYP_LEGACY_DIS];
    assign pair_swap_disable              = ctrl[`PHX_BYP_PAIR_SWAP_DIS];
    assign polarity_correct_disable       = ctrl[`PHX_BYP_POLARITY_DIS];
    assign parallel_detect_honour         = ctrl[`PHX_BYP_PARALLEL_DET];
    assign pulse_shaping_disable          = ctrl[`PHX_BYP_PULSE_SHAPE];
    assign auto_next_page_disable         = ctrl[`PHX_BYP_NEXT_PAGE_DIS];
    assign clock_output_pin_enable        = ctrl[`PHX_BYP_CLK_OUT_EN];

    // =======================================================
    // Read path
    always_comb begin
        next_rdata = `PHX_UNMAPPED_VALUE;
        if (rd_cap) begin
            next_rdata = `PHX_CAP_VALUE;
        end else if (rd_fast) begin
            next_rdata = {fast_descrambler_locked, fast_flags[5], fast_flags[4], fast_link_up,
                          fast_flags[3:0], 8'h00};
        end else if (rd_giga) begin
            next_rdata = {giga_descrambler_locked, giga_flags[6], giga_flags[5], giga_link_up,
                          giga_flags[4:0], legacy_live, crossover_error_seen, 5'h00};
        end else if (rd_bypass) begin
            next_rdata = ctrl;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mgmt_rdata <= 16'h0000;
        end else if (mgmt_rd) begin
            mgmt_rdata <= next_rdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rvalid <= mgmt_rd;
        end
    end

    // =======================================================
    // Assertions
    default clocking cb @(posedge clk_sys);
    endclocking

    default disable iff (rst);

    sequence s_fast_read_quiet;
        rd_fast && (fast_event == '0);
    endsequence

    sequence s_fast_cleared;
        fast_flags == '0;
    endsequence

    property p_cap_fixed;
        rd_cap |=> (mgmt_rvalid && mgmt_rdata == 16'h3000);
    endproperty
    a_cap_fixed: assert property (p_cap_fixed) else $error("capability readback wrong");

    property p_fast_live;
        rd_fast |=> (mgmt_rdata[15] == $past(fast_descrambler_locked) && mgmt_rdata[12] == $past(fast_link_up));
    endproperty
    a_fast_live: assert property (p_fast_live) else $error("fast live status wrong");

    property p_fast_reserved;
        rd_fast |=> (mgmt_rdata[7:0] == 8'h00);
    endproperty
    a_fast_reserved: assert property (p_fast_reserved) else $error("fast reserved bits nonzero");

    property p_fast_read_clears;
        s_fast_read_quiet |=> s_fast_cleared;
    endproperty
    a_fast_read_clears: assert property (p_fast_read_clears) else $error("fast flags not cleared by read");

    property p_fast_flag_shown;
        (fast_event[5] && !soft_reset) ##1 rd_fast |=> mgmt_rdata[14];
    endproperty
    a_fast_flag_shown: assert property (p_fast_flag_shown) else $error("fast lock error flag lost");

    property p_set_beats_clear;
        (rd_giga && giga_event[0]) |=> giga_flags[0];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) else $error("event lost on clearing read");

    property p_giga_hold;
        (giga_flags[6] && !giga_clear) |=> giga_flags[6];
    endproperty
    a_giga_hold: assert property (p_giga_hold) else $error("giga flag dropped without read");

    property p_giga_live;
        rd_giga |=> (mgmt_rdata[15] == $past(giga_descrambler_locked) && mgmt_rdata[12] == $past(giga_link_up)
                     && mgmt_rdata[4:0] == 5'h00);
    endproperty
    a_giga_live: assert property (p_giga_live) else $error("giga live status wrong");

    property p_legacy_gate;
        rd_giga |=> (mgmt_rdata[6] == ($past(legacy_partner_seen) && !$past(legacy_detect_disable)));
    endproperty
    a_legacy_gate: assert property (p_legacy_gate) else $error("legacy detect bit wrong");

    property p_crossover;
        rd_giga |=> (mgmt_rdata[5] == $past(crossover_error_seen));
    endproperty
    a_crossover: assert property (p_crossover) else $error("crossover bit wrong");

    property p_write_takes;
        (wr_bypass && strap_done && !soft_reset) |=> (tx_disable == $past(mgmt_wdata[15])
                                                      && ctrl[8] == 1'b0 && auto_next_page_disable == $past(mgmt_wdata[1]));
    endproperty
    a_write_takes: assert property (p_write_takes) else $error("bypass write not applied");

    property p_sticky_kept;
        (soft_reset && sticky_reset_enable && strap_done) |=>
            ((ctrl & 16'h00FB) == ($past(ctrl) & 16'h00FB) && !tx_disable && !pulse_shaping_disable);
    endproperty
    a_sticky_kept: assert property (p_sticky_kept) else $error("sticky bits lost on soft reset");

    property p_sticky_default;
        (soft_reset && !sticky_reset_enable && strap_done) |=>
            (forced_auto_mdix_disable && parallel_detect_honour && !legacy_detect_disable
             && clock_output_pin_enable == strap_latched);
    endproperty
    a_sticky_default: assert property (p_sticky_default) else $error("sticky defaults not restored");

    property p_strap_load;
        $rose(strap_done) |-> (clock_output_pin_enable == $past(config_strap_default) && parallel_detect_honour);
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("strap not loaded");

    property p_rvalid_once;
        mgmt_rd ##1 !mgmt_rd |=> !mgmt_rvalid;
    endproperty
    a_rvalid_once: assert property (p_rvalid_once) else $error("read valid stuck");

    property p_ctrl_steady;
        (!wr_bypass && !soft_reset && strap_done) |=> $stable(ctrl);
    endproperty
    a_ctrl_steady: assert property (p_ctrl_steady) else $error("bypass control changed unprompted");

    sequence s_bypass_write;
        wr_bypass && strap_done && !soft_reset;
    endsequence

    sequence s_giga_read_quiet;
        rd_giga && (giga_event == '0);
    endsequence

    property p_write_coding;
        s_bypass_write |=> ({bypass_4b5b, bypass_scrambler, bypass_descrambler}
                            == $past(mgmt_wdata[14:12]));
    endproperty
    a_write_coding: assert property (p_write_coding) else $error("coding write lost");

    property p_write_pcs;
        s_bypass_write |=> ({bypass_pcs_rx, bypass_pcs_tx, bypass_link_fail_inhibit_timer}
                            == $past(mgmt_wdata[11:9]));
    endproperty
    a_write_pcs: assert property (p_write_pcs) else $error("pcs write lost");

    property p_write_sticky;
        s_bypass_write |=> ({forced_auto_mdix_disable, legacy_detect_disable, pair_swap_disable,
                             polarity_correct_disable} == $past(mgmt_wdata[7:4]));
    endproperty
    a_write_sticky: assert property (p_write_sticky) else $error("sticky write lost");

    property p_write_tail;
        s_bypass_write |=> ({parallel_detect_honour, pulse_shaping_disable, clock_output_pin_enable}
                            == {$past(mgmt_wdata[3]), $past(mgmt_wdata[2]), $past(mgmt_wdata[0])});
    endproperty
    a_write_tail: assert property (p_write_tail) else $error("low write lost");

    property p_giga_read_clears;
        s_giga_read_quiet |=> (giga_flags == '0);
    endproperty
    a_giga_read_clears: assert property (p_giga_read_clears) else $error("giga flags kept");

    property p_giga_flag_shown;
        (giga_event[0] && !soft_reset) ##1 !giga_clear ##1 rd_giga |=> mgmt_rdata[7];
    endproperty
    a_giga_flag_shown: assert property (p_giga_flag_shown) else $error("carrier flag lost");

    property p_fast_set_wins;
        (rd_fast && fast_event[0]) |=> fast_flags[0];
    endproperty
    a_fast_set_wins: assert property (p_fast_set_wins) else $error("fast event lost");

    property p_soft_clears;
        (soft_reset && fast_event == '0 && giga_event == '0) |=> (fast_flags == '0 && giga_flags == '0);
    endproperty
    a_soft_clears: assert property (p_soft_clears) else $error("flags kept on soft reset");

    property p_soft_nonsticky;
        (soft_reset && strap_done) |=> (ctrl[15:8] == 8'h00 && !pulse_shaping_disable);
    endproperty
    a_soft_nonsticky: assert property (p_soft_nonsticky) else $error("plain bits kept");

endmodule : phx_regs

// *** phx_regs_tb.sv ***
module phx_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Stimulus and observation
    logic               clk_sys = 1'b0;
    logic               rst = 1'b1;
    logic               soft_reset = 1'b0;
    logic               sticky_reset_enable = 1'b0;
    logic               config_strap_default = 1'b1;
    logic               fast_descrambler_locked = 1'b0;
    logic               fast_link_up = 1'b0;
    logic [5:0]         fast_event = 6'h00;
    logic               giga_descrambler_locked = 1'b0;
    logic               giga_link_up = 1'b0;
    logic [6:0]         giga_event = 7'h00;
    logic               legacy_partner_seen = 1'b0;
    logic               crossover_error_seen = 1'b0;
    phx_pkg::phx_addr_t mgmt_addr;
    logic               mgmt_rd;
    logic               mgmt_wr;
    phx_pkg::phx_word_t mgmt_wdata;
    phx_pkg::phx_word_t mgmt_rdata;
    logic               mgmt_rvalid;
    wire logic [15:0]   ctl_out;
    int                 miscompares = 0;
    int                 num_checks = 0;
    int                 cycles = 0;

    always #12.5 clk_sys = ~clk_sys;
    assign ctl_out[8] = 1'b0;

    phx_mgmt_host i_host (.clk_sys(clk_sys), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
        .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

    phx_regs i_dut (.clk_sys(clk_sys), .rst(rst), .soft_reset(soft_reset),
        .sticky_reset_enable(sticky_reset_enable), .config_strap_default(config_strap_default),
        .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata),
        .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
        .fast_descrambler_locked(fast_descrambler_locked), .fast_link_up(fast_link_up), .fast_event(fast_event),
        .giga_descrambler_locked(giga_descrambler_locked), .giga_link_up(giga_link_up), .giga_event(giga_event),
        .legacy_partner_seen(legacy_partner_seen), .crossover_error_seen(crossover_error_seen),
        .tx_disable(ctl_out[15]), .bypass_4b5b(ctl_out[14]), .bypass_scrambler(ctl_out[13]),
        .bypass_descrambler(ctl_out[12]), .bypass_pcs_rx(ctl_out[11]), .bypass_pcs_tx(ctl_out[10]),
        .bypass_link_fail_inhibit_timer(ctl_out[9]), .forced_auto_mdix_disable(ctl_out[7]),
        .legacy_detect_disable(ctl_out[6]), .pair_swap_disable(ctl_out[5]),
        .polarity_correct_disable(ctl_out[4]), .parallel_detect_honour(ctl_out[3]),
        .pulse_shaping_disable(ctl_out[2]), .auto_next_page_disable(ctl_out[1]),
        .clock_output_pin_enable(ctl_out[0]));

    // ==========================================================
    // Shared helpers
    task automatic check(input string what, input phx_pkg::phx_word_t seen, input phx_pkg::phx_word_t exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rd_chk(input phx_pkg::phx_addr_t addr, input phx_pkg::phx_word_t exp, input string what);
        phx_pkg::phx_word_t data;
        logic               ok;
        i_host.rd(addr, data, ok);
        check({what, " valid"}, {15'h0000, ok}, 16'h0001);
        check(what, data, exp);
    endtask : rd_chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // Scenarios
    task automatic t_reset_values;
        rd_chk(5'h0F, 16'h3000, "capability");
        rd_chk(5'h10, 16'h0000, "fast status");
        rd_chk(5'h11, 16'h0000, "giga status");
        rd_chk(5'h12, 16'h0089, "bypass default");
        check("controls", ctl_out & 16'hFEFF, 16'h0089);
        rd_chk(5'h1F, 16'h0000, "unmapped");
    endtask : t_reset_values

    task automatic t_fast_flags;
        logic [5:0] m;
        fast_descrambler_locked = 1'b1;
        fast_link_up = 1'b1;
        for (int i = 0; i < 6; i++) begin
            m = 6'h01 << i;
            @(negedge clk_sys) fast_event = m;
            @(negedge clk_sys) fast_event = 6'h00;
            repeat (3) @(negedge clk_sys);
            rd_chk(5'h10, {1'b1, m[5], m[4], 1'b1, m[3:0], 8'h00}, "fast flag");
            rd_chk(5'h10, 16'h9000, "fast cleared");
        end
    endtask : t_fast_flags

    task automatic t_giga_flags;
        logic [6:0] m;
        giga_descrambler_locked = 1'b1;
        legacy_partner_seen = 1'b1;
        crossover_error_seen = 1'b1;
        for (int i = 0; i < 7; i++) begin
            m = 7'h01 << i;
            @(negedge clk_sys) giga_event = m;
            @(negedge clk_sys) giga_event = 7'h00;
            rd_chk(5'h11, {1'b1, m[6], m[5], 1'b0, m[4:0], 2'b11, 5'h00}, "giga flag");
            rd_chk(5'h11, 16'h8060, "giga cleared");
        end
        giga_link_up = 1'b1;
        i_host.wr(5'h12, 16'h00C9);
        rd_chk(5'h11, 16'h9020, "legacy off");
        i_host.wr(5'h12, 16'h0089);
    endtask : t_giga_flags

    task automatic t_bypass_rw;
        phx_pkg::phx_word_t pats [4] = '{16'hFFFF, 16'h0000, 16'hA5A5, 16'h5A5A};
        foreach (pats[i]) begin
            i_host.wr(5'h12, pats[i]);
            rd_chk(5'h12, pats[i] & 16'hFEFF, "bypass");
            check("controls", ctl_out & 16'hFEFF, pats[i] & 16'hFEFF);
            check("pins", ctl_out & 16'h0007, pats[i] & 16'h0007);
        end
        for (int a = 15; a < 18; a++) begin
            i_host.wr(a[4:0], 16'hFFFF);
        end
        rd_chk(5'h0F, 16'h3000, "capability ro");
        rd_chk(5'h12, 16'h5A5A & 16'hFEFF, "bypass kept");
    endtask : t_bypass_rw

    task automatic t_soft_reset;
        i_host.wr(5'h12, 16'hFFFF);
        @(negedge clk_sys) sticky_reset_enable = 1'b1;
        soft_reset = 1'b1;
        @(negedge clk_sys) soft_reset = 1'b0;
        rd_chk(5'h12, 16'h00FB, "sticky kept");
        i_host.wr(5'h12, 16'hFFFF);
        @(negedge clk_sys) sticky_reset_enable = 1'b0;
        soft_reset = 1'b1;
        @(negedge clk_sys) soft_reset = 1'b0;
        rd_chk(5'h12, 16'h0089, "sticky default");
        check("controls", ctl_out & 16'hFEFF, 16'h0089);
    endtask : t_soft_reset

    task automatic t_set_beats_clear;
        phx_pkg::phx_word_t data;
        logic               ok;
        fast_descrambler_locked = 1'b0;
        fast_link_up = 1'b0;
        @(negedge clk_sys) fast_event = 6'h20;
        @(negedge clk_sys) fast_event = 6'h00;
        fork
            i_host.rd(5'h10, data, ok);
            begin
                @(negedge clk_sys) fast_event = 6'h01;
                @(negedge clk_sys) fast_event = 6'h00;
            end
        join
        check("flag before clear", data, 16'h4000);
        rd_chk(5'h10, 16'h0100, "new event kept");
        rd_chk(5'h10, 16'h0000, "all cleared");
    endtask : t_set_beats_clear

    task automatic t_strap_low;
        phx_pkg::phx_word_t data;
        logic               ok;
        {giga_descrambler_locked, giga_link_up, legacy_partner_seen, crossover_error_seen} = 4'h0;
        @(negedge clk_sys) fast_event = 6'h20;
        fork
            i_host.rd(5'h10, data, ok);
            @(negedge clk_sys) fast_event = 6'h00;
        join
        check("flag at once", data, 16'h4000);
        fork
            i_host.rd(5'h11, data, ok);
            begin
                @(negedge clk_sys) giga_event = 7'h01;
                @(negedge clk_sys) giga_event = 7'h00;
            end
        join
        check("giga before clear", data, 16'h0000);
        rd_chk(5'h11, 16'h0080, "giga kept");
        @(negedge clk_sys) fast_event = 6'h01;
        @(negedge clk_sys) fast_event = 6'h00;
        config_strap_default = 1'b0;
        rst = 1'b1;
        @(negedge clk_sys) check("in reset", ctl_out & 16'hFEFF, 16'h0088);
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        rd_chk(5'h12, 16'h0088, "strap low");
        rd_chk(5'h10, 16'h0000, "fast after reset");
        i_host.wr(5'h12, 16'h00FF);
        @(negedge clk_sys) giga_event = 7'h40;
        @(negedge clk_sys) giga_event = 7'h00;
        soft_reset = 1'b1;
        @(negedge clk_sys) soft_reset = 1'b0;
        rd_chk(5'h11, 16'h0000, "soft clears");
        rd_chk(5'h12, 16'h0088, "soft strap low");
    endtask : t_strap_low

    // ==========================================================
    // Watchdog and main sequence
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        t_reset_values();
        t_fast_flags();
        t_giga_flags();
        t_bypass_rw();
        t_soft_reset();
        t_set_beats_clear();
        t_strap_low();
        tally_and_finish();
    end

endmodule : phx_regs_tb

// *** phx_sticky_flag.sv ***
module phx_sticky_flag #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] event_in,
    input  wire logic         clear,
    output logic      [W-1:0] flags
);

    // =======================================================
    // Latch events; a new event outranks the clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~{W{clear}}) | event_in;
        end
    end

endmodule : phx_sticky_flag
